/* File: hdl/ledfm_defines.svh */
// constants for the led fault manager
`ifndef LEDFM_DEFINES_SVH
`define LEDFM_DEFINES_SVH
`define LEDFM_SHORT_CYCLES   2
`define LEDFM_HICCUP_CYCLES  16000
`define LEDFM_CNT_W          15
`endif

/* File: hdl/ledfm_pkg.sv */
// types for the led fault manager
`include "ledfm_defines.svh"
package ledfm_pkg;
  typedef enum logic [1:0] {
    LEDFM_RUN,
    LEDFM_HICCUP,
    LEDFM_RETRY
  } ledfm_hic_state_type;

  typedef struct packed {
    logic ovp_hit;
    logic ovp_below_hyst;
    logic sense_oc;
    logic temp_over_shutdown;
    logic temp_below_release;
    logic supply_low;
    logic supply_above_rise;
    logic rail_low;
    logic freq_high;
    logic switch_oc;
  } ledfm_sense_type;

  typedef struct packed {
    logic gate_drive;
    logic dim_switch_drive;
    logic standby;
    logic comp_reset;
  } ledfm_drive_type;
endpackage : ledfm_pkg

/* File: hdl/ledfm_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ledfm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : ledfm_sync
`default_nettype wire

/* File: hdl/ledfm_top.sv */
// fault protection and reporting for a switching led current controller
`timescale 1ns/1ps
`default_nettype none
`include "ledfm_defines.svh"
module ledfm_top #(
  parameter int HICCUP_CYCLES = `LEDFM_HICCUP_CYCLES,
  parameter int SHORT_CYCLES  = `LEDFM_SHORT_CYCLES
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // switching cycle and configuration
  input  wire logic                      sw_cycle_start,
  input  wire logic                      boost_mode,
  input  wire logic                      startup_done,
  input  wire logic                      pwm_gate_request,
  input  wire logic                      dim_request,
  // analog comparator results, asynchronous
  input  wire ledfm_pkg::ledfm_sense_type sense_async,
  // drives
  output var  ledfm_pkg::ledfm_drive_type drive,
  // open-drain fault flag
  input  wire logic                      fault_flag_n_in,
  output var  logic                      fault_flag_n_out,
  output var  logic                      fault_flag_n_oe
);
  import ledfm_pkg::*;

  localparam int CW = `LEDFM_CNT_W;

  ledfm_sense_type     sense;
  ledfm_hic_state_type hic_reg;
  ledfm_hic_state_type hic_next;
  logic [CW-1:0]       hic_cnt_reg;
  logic [1:0]          short_cnt_reg;
  logic                short_det;
  logic                ovp_reg;
  logic                therm_reg;
  logic                uvlo_reg;
  logic                rail_fault;
  logic                freq_fault;
  logic                climit_reg;
  logic                report;
  logic                standby_any;
  logic                comp_any;
  logic                gate_block;
  logic                dim_block;

  ledfm_sync #(.WIDTH($bits(ledfm_sense_type))) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (sense_async),
    .dout  (sense)
  );

  function automatic logic [CW-1:0] cnt_limit(input int n);
    cnt_limit = CW'(n - 1);
  endfunction : cnt_limit

  // over-voltage latch with hysteresis release
  always_ff @(posedge mclk) begin
    if (reset) begin
      ovp_reg <= 1'b0;
    end else if (sense.ovp_hit) begin
      ovp_reg <= 1'b1;
    end else if (sense.ovp_below_hyst) begin
      ovp_reg <= 1'b0;
    end
  end

  chk_ovp_gate_low: assert property (@(posedge mclk) disable iff (reset)
    ovp_reg |=> !drive.gate_drive && !drive.dim_switch_drive)
    else $error("drives high during over-voltage");
  chk_ovp_immediate: assert property (@(posedge mclk) disable iff (reset)
    sense.ovp_hit |=> !drive.gate_drive && !drive.dim_switch_drive)
    else $error("drives high on over-voltage hit");
  chk_ovp_flag_hold: assert property (@(posedge mclk) disable iff (reset)
    ovp_reg && !sense.ovp_below_hyst |=> ovp_reg)
    else $error("over-voltage released early");

  // thermal latch, released below lower level
  always_ff @(posedge mclk) begin
    if (reset) begin
      therm_reg <= 1'b0;
    end else if (sense.temp_over_shutdown) begin
      therm_reg <= 1'b1;
    end else if (sense.temp_below_release) begin
      therm_reg <= 1'b0;
    end
  end

  chk_therm_standby: assert property (@(posedge mclk) disable iff (reset)
    therm_reg |=> drive.standby && !drive.gate_drive && fault_flag_n_oe)
    else $error("thermal response missing");
  chk_therm_hold: assert property (@(posedge mclk) disable iff (reset)
    therm_reg && !sense.temp_below_release |=> therm_reg)
    else $error("thermal released early");

  // supply lockout, released on rising threshold
  always_ff @(posedge mclk) begin
    if (reset) begin
      uvlo_reg <= 1'b1;
    end else if (sense.supply_low) begin
      uvlo_reg <= 1'b1;
    end else if (sense.supply_above_rise) begin
      uvlo_reg <= 1'b0;
    end
  end

  chk_uvlo_silent: assert property (@(posedge mclk) disable iff (reset)
    uvlo_reg && !therm_reg && !ovp_reg && !rail_fault && !freq_fault
    && hic_reg != LEDFM_HICCUP |=> !fault_flag_n_oe)
    else $error("supply lockout reported");
  chk_uvlo_hold: assert property (@(posedge mclk) disable iff (reset)
    uvlo_reg && !sense.supply_above_rise |=> uvlo_reg)
    else $error("supply lockout released early");
  chk_uvlo_drives: assert property (@(posedge mclk) disable iff (reset)
    uvlo_reg |=> !drive.gate_drive && !drive.dim_switch_drive
    && drive.standby && drive.comp_reset)
    else $error("supply lockout response missing");

  assign rail_fault = startup_done && sense.rail_low;
  assign freq_fault = sense.freq_high;

  chk_freq_gate: assert property (@(posedge mclk) disable iff (reset)
    freq_fault |=> !drive.gate_drive && fault_flag_n_oe)
    else $error("frequency fault response missing");
  chk_rail_standby: assert property (@(posedge mclk) disable iff (reset)
    rail_fault |=> drive.standby && drive.comp_reset && !drive.gate_drive && fault_flag_n_oe)
    else $error("rail fault response missing");

  // cycle-by-cycle current limit, cleared at next cycle start
  always_ff @(posedge mclk) begin
    if (reset) begin
      climit_reg <= 1'b0;
    end else if (sense.switch_oc) begin
      climit_reg <= 1'b1;
    end else if (sw_cycle_start) begin
      climit_reg <= 1'b0;
    end
  end

  chk_climit_hold: assert property (@(posedge mclk) disable iff (reset)
    climit_reg && !sw_cycle_start |=> !drive.gate_drive)
    else $error("gate pulse not ended");
  chk_limit_cut: assert property (@(posedge mclk) disable iff (reset)
    sense.switch_oc |=> !drive.gate_drive)
    else $error("gate high over current limit");

  // count switching cycles with sense above short threshold
  always_ff @(posedge mclk) begin
    if (reset) begin
      short_cnt_reg <= '0;
    end else if (!sense.sense_oc || !boost_mode) begin
      short_cnt_reg <= '0;
    end else if (sw_cycle_start && short_cnt_reg != 2'(SHORT_CYCLES)) begin
      short_cnt_reg <= short_cnt_reg + 2'h1;
    end
  end

  assign short_det = boost_mode && short_cnt_reg == 2'(SHORT_CYCLES);

  chk_short_boost: assert property (@(posedge mclk) disable iff (reset)
    !boost_mode |-> !short_det)
    else $error("short detected outside boost");
  chk_short_filter: assert property (@(posedge mclk) disable iff (reset)
    short_det |-> $past(sense.sense_oc) && $past(sense.sense_oc, 2))
    else $error("short declared without two cycles over threshold");
  chk_short_dim_cut: assert property (@(posedge mclk) disable iff (reset)
    short_det |=> !drive.dim_switch_drive)
    else $error("dim drive high on short");

  // hiccup sequencer
  always_comb begin
    hic_next = hic_reg;
    unique case (hic_reg)
      LEDFM_RUN: begin
        if (short_det) begin
          hic_next = LEDFM_HICCUP;
        end
      end
      LEDFM_HICCUP: begin
        if (sw_cycle_start && hic_cnt_reg == cnt_limit(HICCUP_CYCLES)) begin
          hic_next = LEDFM_RETRY;
        end
      end
      LEDFM_RETRY: begin
        if (short_det) begin
          hic_next = LEDFM_HICCUP;
        end else if (sw_cycle_start && !sense.sense_oc) begin
          hic_next = LEDFM_RUN;
        end
      end
      default: begin
        hic_next = LEDFM_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hic_reg <= LEDFM_RUN;
    end else begin
      hic_reg <= hic_next;
    end
  end

  chk_short_enters: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_RUN && short_det |=> hic_reg == LEDFM_HICCUP)
    else $error("short did not start hiccup");
  chk_retry_exit: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_RETRY && sw_cycle_start && !sense.sense_oc && !short_det
    |=> hic_reg == LEDFM_RUN)
    else $error("retry did not resume");
  chk_retry_rearm: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_RETRY && short_det |=> hic_reg == LEDFM_HICCUP && hic_cnt_reg == '0)
    else $error("retry short did not restart full hiccup");

  always_ff @(posedge mclk) begin
    if (reset) begin
      hic_cnt_reg <= '0;
    end else if (hic_reg != LEDFM_HICCUP) begin
      hic_cnt_reg <= '0;
    end else if (sw_cycle_start) begin
      hic_cnt_reg <= hic_cnt_reg + CW'(1);
    end
  end

  chk_hiccup_len: assert property (@(posedge mclk) disable iff (reset)
    $rose(hic_reg == LEDFM_HICCUP) |-> hic_cnt_reg == '0)
    else $error("hiccup period not restarted");
  chk_hiccup_hold: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_HICCUP && hic_cnt_reg < cnt_limit(HICCUP_CYCLES) |=> hic_reg == LEDFM_HICCUP)
    else $error("hiccup ended early");

  // reportable sources are or-ed onto the flag
  assign report = ovp_reg || therm_reg || rail_fault || freq_fault
                  || hic_reg == LEDFM_HICCUP;
  assign standby_any = uvlo_reg || therm_reg || ovp_reg || rail_fault;
  assign comp_any    = standby_any || hic_reg == LEDFM_HICCUP;
  assign gate_block  = comp_any || freq_fault || climit_reg || sense.switch_oc;
  assign dim_block   = uvlo_reg || ovp_reg || hic_reg == LEDFM_HICCUP;

  // drives: over-voltage cuts gate and dim the cycle after the latch input rises, standby and comp reset a cycle later
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive <= '0;
    end else begin
      drive.gate_drive       <= pwm_gate_request && !gate_block
                                && !sense.ovp_hit;
      drive.dim_switch_drive <= dim_request && !dim_block && !short_det
                                && !sense.ovp_hit;
      drive.standby          <= standby_any;
      drive.comp_reset       <= comp_any;
    end
  end

  chk_hiccup_comp: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_HICCUP |=> drive.comp_reset && fault_flag_n_oe)
    else $error("hiccup without comp reset or flag");
  chk_hiccup_gate: assert property (@(posedge mclk) disable iff (reset)
    hic_reg == LEDFM_HICCUP |=> !drive.gate_drive && !drive.dim_switch_drive)
    else $error("drives high during hiccup");
  chk_gate_follow: assert property (@(posedge mclk) disable iff (reset)
    !gate_block && !sense.ovp_hit |=> drive.gate_drive == $past(pwm_gate_request))
    else $error("gate drive not following request");
  chk_dim_follow: assert property (@(posedge mclk) disable iff (reset)
    !dim_block && !short_det && !sense.ovp_hit |=> drive.dim_switch_drive == $past(dim_request))
    else $error("dim drive not following request");
  chk_standby_comp: assert property (@(posedge mclk) disable iff (reset)
    drive.standby |-> drive.comp_reset)
    else $error("standby without comp reset");

  // open-drain flag: output always low, enable while reporting
  assign fault_flag_n_out = 1'b0;
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_flag_n_oe <= 1'b0;
    end else begin
      fault_flag_n_oe <= report;
    end
  end

  chk_flag_release: assert property (@(posedge mclk) disable iff (reset)
    !report |=> !fault_flag_n_oe)
    else $error("flag held with no fault");
  chk_flag_any: assert property (@(posedge mclk) disable iff (reset)
    report |=> fault_flag_n_oe)
    else $error("flag not driven during fault");
endmodule : ledfm_top
`default_nettype wire

/* File: test/ledfm_host.sv */
// host side of the open-drain fault flag, with its pull-up
`timescale 1ns/1ps
`default_nettype none
module ledfm_host (
  // open-drain flag from the device
  input  wire logic fault_flag_n_out,
  input  wire logic fault_flag_n_oe,
  // resolved pin and host view
  output wire logic fault_flag_n,
  output var  logic fault_seen
);
  // pull-up holds the pin high whenever the device lets go
  assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_out : 1'b1;
  always_comb fault_seen = ~fault_flag_n;
endmodule : ledfm_host
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the led fault manager
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ledfm_pkg::*;
  localparam int HIC = 8;
  logic            mclk      = 1'b0;
  logic            reset     = 1'b1;
  logic            sw_start  = 1'b0;
  logic            boost     = 1'b0;
  logic            started   = 1'b1;
  logic            gate_req  = 1'b1;
  logic            dim_req   = 1'b1;
  ledfm_sense_type sns       = '0;
  ledfm_drive_type drv;
  logic            flag_out;
  logic            flag_oe;
  wire logic       flag_pin;
  logic            fault_seen;
  int              err_total = 0;
  int              compares  = 0;

  always #10 mclk = ~mclk;

  ledfm_top #(.HICCUP_CYCLES(HIC), .SHORT_CYCLES(2)) u_ledfm_top (
    .mclk(mclk), .reset(reset), .sw_cycle_start(sw_start), .boost_mode(boost),
    .startup_done(started), .pwm_gate_request(gate_req), .dim_request(dim_req),
    .sense_async(sns), .drive(drv), .fault_flag_n_in(flag_pin),
    .fault_flag_n_out(flag_out), .fault_flag_n_oe(flag_oe));

  ledfm_host u_ledfm_host (.fault_flag_n_out(flag_out), .fault_flag_n_oe(flag_oe),
    .fault_flag_n(flag_pin), .fault_seen(fault_seen));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic pulse(input int n);
    repeat (n) begin
      sw_start = 1'b1;
      tick(1);
      sw_start = 1'b0;
      tick(1);
    end
  endtask : pulse

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares += 1;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_total += 1;
    end
  endtask : chk

  // drive order: gate, dim, standby, comp reset; lets the synchroniser settle first
  task automatic look(input string what, input logic [3:0] mask, input logic [3:0] exp,
                      input logic fexp);
    tick(6);
    chk({what, " drive"}, exp, drv & mask);
    chk({what, " flag"}, {3'h0, fexp}, {3'h0, fault_seen});
  endtask : look

  task automatic ovp_thermal_case;
    sns.ovp_hit = 1'b1;
    look("ovp set", 4'hF, 4'h3, 1'b1);
    sns.ovp_hit = 1'b0;
    look("ovp hold", 4'hF, 4'h3, 1'b1);
    sns.temp_over_shutdown = 1'b1;
    sns.ovp_below_hyst = 1'b1;
    look("ovp gone hot", 4'hB, 4'h3, 1'b1);
    sns.ovp_below_hyst = 1'b0;
    sns.temp_over_shutdown = 1'b0;
    look("thermal hold", 4'hB, 4'h3, 1'b1);
    sns.temp_below_release = 1'b1;
    look("all clear", 4'hF, 4'hC, 1'b0);
    sns.temp_below_release = 1'b0;
  endtask : ovp_thermal_case

  task automatic supply_case;
    sns.supply_above_rise = 1'b0;
    sns.supply_low = 1'b1;
    look("uvlo", 4'hF, 4'h3, 1'b0);
    sns.supply_low = 1'b0;
    look("uvlo hold", 4'hF, 4'h3, 1'b0);
    sns.supply_above_rise = 1'b1;
    look("uvlo clear", 4'hF, 4'hC, 1'b0);
  endtask : supply_case

  task automatic rail_freq_case;
    started = 1'b0;
    sns.rail_low = 1'b1;
    look("rail before startup", 4'hF, 4'hC, 1'b0);
    started = 1'b1;
    look("rail", 4'hB, 4'h3, 1'b1);
    sns.rail_low = 1'b0;
    sns.freq_high = 1'b1;
    look("freq", 4'h8, 4'h0, 1'b1);
    sns.freq_high = 1'b0;
    look("freq clear", 4'hF, 4'hC, 1'b0);
  endtask : rail_freq_case

  task automatic limit_case;
    sns.switch_oc = 1'b1;
    look("limit", 4'hF, 4'h4, 1'b0);
    sns.switch_oc = 1'b0;
    look("limit hold", 4'h8, 4'h0, 1'b0);
    pulse(1);
    look("limit end", 4'hF, 4'hC, 1'b0);
  endtask : limit_case

  task automatic short_case;
    sns.sense_oc = 1'b1;
    tick(6);
    pulse(4);
    look("no boost", 4'hF, 4'hC, 1'b0);
    boost = 1'b1;
    pulse(1);
    look("one cycle", 4'hF, 4'hC, 1'b0);
    pulse(2);
    look("short", 4'hD, 4'h1, 1'b1);
    // one cycle already counted; still off one cycle before the retry
    pulse(HIC - 2);
    look("hiccup hold", 4'hD, 4'h1, 1'b1);
    // retry sees the short, a fresh off period has one cycle left
    pulse(HIC);
    look("retry short", 4'hD, 4'h1, 1'b1);
    sns.sense_oc = 1'b0;
    pulse(HIC + 4);
    look("recover", 4'hF, 4'hC, 1'b0);
    gate_req = 1'b0;
    look("gate request off", 4'hF, 4'h4, 1'b0);
    gate_req = 1'b1;
    dim_req = 1'b0;
    look("dim request off", 4'hF, 4'h8, 1'b0);
    dim_req = 1'b1;
    boost = 1'b0;
  endtask : short_case

  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    sns.supply_above_rise = 1'b1;
    tick(3);
    reset = 1'b0;
    look("idle", 4'hF, 4'hC, 1'b0);
    ovp_thermal_case();
    supply_case();
    rail_freq_case();
    limit_case();
    short_case();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
